// [inc/pic_pkg.sv]
// Shared constants for the interrupt controller command and trigger block
package pic_pkg;

	// ----------------------------------------------------------------
	// I/O port map of the device
	// ----------------------------------------------------------------
	localparam logic [11:0] BASE_PORT    = 12'h020;
	localparam logic [11:0] MASK_PORT    = 12'h021;
	localparam logic [11:0] TRIGGER_PORT = 12'h4d0;

	// ----------------------------------------------------------------
	// Command byte fields on the base port
	// ----------------------------------------------------------------
	localparam int          CMD_CODE_HI  = 7;
	localparam int          CMD_CODE_LO  = 5;
	localparam int          SEL_HI       = 4;
	localparam int          SEL_LO       = 3;
	localparam int          INIT_BIT     = 4;
	localparam int          SMM_BIT      = 6;
	localparam int          SPECIAL_MASK_ENABLE_BIT     = 5;
	localparam int          POLL_BIT     = 2;
	localparam int          RDSEL_EN_BIT = 1;
	localparam int          RDSEL_BIT    = 0;
	localparam logic [1:0]  SEL_OP_COMMAND_WORD_TWO     = 2'h0;
	localparam logic [1:0]  SEL_OP_COMMAND_WORD_THREE     = 2'h1;

	// Rotate / end-of-interrupt codes in bits 7:5
	localparam logic [2:0]  CODE_ROT_AUTO_END_OF_INTERRUPT_CLR = 3'h0;
	localparam logic [2:0]  CODE_NS_EOI       = 3'h1;
	localparam logic [2:0]  CODE_SP_EOI       = 3'h3;
	localparam logic [2:0]  CODE_ROT_AUTO_END_OF_INTERRUPT_SET = 3'h4;
	localparam logic [2:0]  CODE_ROT_NS_EOI   = 3'h5;
	localparam logic [2:0]  CODE_SET_PRIO     = 3'h6;
	localparam logic [2:0]  CODE_ROT_SP_EOI   = 3'h7;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  TRIGGER_RST   = 8'h00;
	localparam logic [7:0]  TRIGGER_WMASK = 8'hf8;
	localparam logic [2:0]  LOWEST_RST    = 3'h7;
	localparam int          POLL_VALID_BIT = 7;

	typedef enum logic {
		SHOW_REQUEST    = 1'b0,
		SHOW_IN_SERVICE = 1'b1
	} status_sel_t;

	// ----------------------------------------------------------------
	// Host controller register map (word index on the host register port)
	// ----------------------------------------------------------------
	localparam logic [2:0]  HREG_ADDR   = 3'h0;
	localparam logic [2:0]  HREG_WRITE  = 3'h1;
	localparam logic [2:0]  HREG_READ   = 3'h2;
	localparam logic [2:0]  HREG_RESULT = 3'h3;
	localparam logic [2:0]  HREG_STATUS = 3'h4;
	localparam logic [2:0]  HREG_MASK   = 3'h5;
	localparam int          EV_READ_DONE = 0;
	localparam int          EV_INTR_RISE = 1;
	localparam int          LIVE_INTR    = 2;
	localparam logic [1:0]  HSTATUS_RST  = 2'h0;
	localparam logic [1:0]  HMASK_RST    = 2'h0;

endpackage

// [inc/pic_if.sv]
// I/O bus between processor side and the interrupt controller
`timescale 1ns/1ps
`default_nettype none

interface pic_if;
	logic [11:0] io_addr;   // I/O port address
	logic [7:0]  io_wdata;  // write byte
	logic        io_wr;     // write strobe, one cycle
	logic        io_rd;     // read strobe, one cycle
	logic [7:0]  io_rdata;  // read byte, cycle after io_rd
	logic        intr;      // interrupt request to processor

	modport dev (
		input  io_addr,
		input  io_wdata,
		input  io_wr,
		input  io_rd,
		output io_rdata,
		output intr
	);

	modport host (
		output io_addr,
		output io_wdata,
		output io_wr,
		output io_rd,
		input  io_rdata,
		input  intr
	);
endinterface

`default_nettype wire

// [logic/pic_device.sv]
// Master interrupt controller: command words, priority and trigger modes
`timescale 1ns/1ps
`default_nettype none

module pic_device (
	input  wire logic       clock,      // system clock
	input  wire logic       srst,       // processor hard reset
	input  wire logic       ce,         // clock enable
	pic_if.dev              bus,        // processor I/O side
	input  wire logic [7:0] irq_in,     // peripheral request lines
	input  wire logic [7:0] line_mask,  // mask register, 1 masks
	input  wire logic       auto_end_of_interrupt_mode,  // auto end of interrupt option
	input  wire logic       inta,       // acknowledge pulse
	output logic            ack_valid,  // acknowledge found a request
	output logic [2:0]      ack_level   // level acknowledged
);

	// ----------------------------------------------------------------
	// Priority helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] rank(input logic [2:0] line, input logic [2:0] low);
		return 3'(line - low - 3'h1);
	endfunction

	function automatic logic [3:0] top(input logic [7:0] v, input logic [2:0] low);
		logic [2:0] idx;
		logic [3:0] res;
		res = 4'h0;
		for (int k = 7; k >= 0; k--) begin
			idx = 3'(low + 3'(k) + 3'h1);
			if (v[idx]) begin
				res = {1'b1, idx};
			end
		end
		return res;
	endfunction

	logic [7:0]  irr_q;
	logic [7:0]  isr_q;
	logic [7:0]  prev_q;
	logic [7:0]  trig_q;
	logic [2:0]  low_q;
	logic        rot_auto_end_of_interrupt_q;
	logic        smm_q;
	logic        poll_q;
	pic_pkg::status_sel_t sel_q;
	logic [7:0]  rdata_q;
	logic        intr_q;

	logic        wr_base, init_wr, op_command_word_two_wr, op_command_word_three_wr, rd_base, rd_ctl, poll_rd, ack_now, ack_go;
	logic [2:0]  code, lvl;
	logic [7:0]  level_sense, cand;
	logic [3:0]  p_top, s_top;
	logic        int_ok;
	logic [7:0]  eoi_clr, isr_set;
	logic        eoi_do;
	logic [2:0]  eoi_line;

	// ----------------------------------------------------------------
	// Port decode
	// ----------------------------------------------------------------
	assign wr_base = bus.io_wr && bus.io_addr == pic_pkg::BASE_PORT;
	assign init_wr = wr_base && bus.io_wdata[pic_pkg::INIT_BIT];
	assign op_command_word_two_wr = wr_base && bus.io_wdata[pic_pkg::SEL_HI:pic_pkg::SEL_LO] == pic_pkg::SEL_OP_COMMAND_WORD_TWO;
	assign op_command_word_three_wr = wr_base && bus.io_wdata[pic_pkg::SEL_HI:pic_pkg::SEL_LO] == pic_pkg::SEL_OP_COMMAND_WORD_THREE;
	assign rd_base = bus.io_rd && bus.io_addr == pic_pkg::BASE_PORT;
	assign rd_ctl  = rd_base || (bus.io_rd && bus.io_addr == pic_pkg::MASK_PORT);
	// read after poll is an acknowledge
	assign poll_rd = rd_ctl && poll_q;
	assign code    = bus.io_wdata[pic_pkg::CMD_CODE_HI:pic_pkg::CMD_CODE_LO];
	assign lvl     = bus.io_wdata[2:0];

	// ----------------------------------------------------------------
	// Priority resolution
	// ----------------------------------------------------------------
	// lines 0 to 2 forced to edge
	assign level_sense = trig_q & pic_pkg::TRIGGER_WMASK;
	// in special mask mode in-service bits only block their own line
	assign cand   = smm_q ? (irr_q & ~line_mask & ~isr_q) : (irr_q & ~line_mask);
	assign p_top  = top(cand, low_q);
	assign s_top  = top(isr_q, low_q);
	assign int_ok = p_top[3] && (smm_q || !s_top[3] || rank(p_top[2:0], low_q) < rank(s_top[2:0], low_q));
	assign ack_now = poll_rd || inta;
	assign ack_go  = ack_now && int_ok;

	// End-of-interrupt target
	always_comb begin
		eoi_do   = 1'b0;
		eoi_line = s_top[2:0];
		if (op_command_word_two_wr) begin
			unique case (code)
				pic_pkg::CODE_NS_EOI, pic_pkg::CODE_ROT_NS_EOI: begin
					eoi_do = s_top[3];
				end
				// level field only with specific flag
				pic_pkg::CODE_SP_EOI, pic_pkg::CODE_ROT_SP_EOI: begin
					eoi_do   = 1'b1;
					eoi_line = lvl;
				end
				default: begin
					eoi_do = 1'b0;
				end
			endcase
		end
	end

	assign eoi_clr = eoi_do ? (8'h01 << eoi_line) : 8'h00;
	assign isr_set = (ack_go && !auto_end_of_interrupt_mode) ? (8'h01 << p_top[2:0]) : 8'h00;

	// ----------------------------------------------------------------
	// Request latch
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			prev_q <= 8'h00;
		end else if (ce) begin
			prev_q <= irq_in;
		end
	end

	always_ff @(posedge clock) begin
		if (srst || (ce && init_wr)) begin
			irr_q <= 8'h00;
		end else if (ce) begin
			for (int i = 0; i < 8; i++) begin
				if (level_sense[i]) begin
					irr_q[i] <= irq_in[i];
				end else if (irq_in[i] && !prev_q[i]) begin
					irr_q[i] <= 1'b1;
				end else if (ack_go && p_top[2:0] == 3'(i)) begin
					irr_q[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// In-service register and rotation
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst || (ce && init_wr)) begin
			isr_q <= 8'h00;
		end else if (ce) begin
			// Set wins when acknowledge meets a clear
			isr_q <= (isr_q & ~eoi_clr) | isr_set;
		end
	end

	always_ff @(posedge clock) begin
		if (srst || (ce && init_wr)) begin
			low_q      <= pic_pkg::LOWEST_RST;
			rot_auto_end_of_interrupt_q <= 1'b0;
		end else if (ce) begin
			if (op_command_word_two_wr) begin
				unique case (code)
					pic_pkg::CODE_ROT_AUTO_END_OF_INTERRUPT_SET: rot_auto_end_of_interrupt_q <= 1'b1;
					pic_pkg::CODE_ROT_AUTO_END_OF_INTERRUPT_CLR: rot_auto_end_of_interrupt_q <= 1'b0;
					pic_pkg::CODE_ROT_NS_EOI: begin
						if (s_top[3]) begin
							low_q <= s_top[2:0];
						end
					end
					pic_pkg::CODE_ROT_SP_EOI, pic_pkg::CODE_SET_PRIO: low_q <= lvl;
					default: begin
					end
				endcase
			end else if (ack_go && auto_end_of_interrupt_mode && rot_auto_end_of_interrupt_q) begin
				// rotate in auto mode on acknowledge
				low_q <= p_top[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Command word three state
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst || (ce && init_wr)) begin
			smm_q <= 1'b0;
			poll_q <= 1'b0;
			sel_q <= pic_pkg::SHOW_REQUEST;
		end else if (ce) begin
			if (op_command_word_three_wr) begin
				if (bus.io_wdata[pic_pkg::SPECIAL_MASK_ENABLE_BIT]) begin
					smm_q <= bus.io_wdata[pic_pkg::SMM_BIT];
				end
				poll_q <= bus.io_wdata[pic_pkg::POLL_BIT];
				if (bus.io_wdata[pic_pkg::RDSEL_EN_BIT]) begin
					sel_q <= pic_pkg::status_sel_t'(bus.io_wdata[pic_pkg::RDSEL_BIT]);
				end
			end else if (rd_ctl) begin
				poll_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Trigger register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			trig_q <= pic_pkg::TRIGGER_RST;
		end else if (ce && bus.io_wr && bus.io_addr == pic_pkg::TRIGGER_PORT) begin
			trig_q <= bus.io_wdata & pic_pkg::TRIGGER_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Read data and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= 8'h00;
			if (poll_rd) begin
				// poll word instead of a register
				rdata_q <= int_ok ? {1'b1, 4'h0, p_top[2:0]} : 8'h00;
			end else if (rd_base) begin
				rdata_q <= (sel_q == pic_pkg::SHOW_IN_SERVICE) ? isr_q : irr_q;
			end else if (bus.io_rd && bus.io_addr == pic_pkg::MASK_PORT) begin
				rdata_q <= line_mask;
			end else if (bus.io_rd && bus.io_addr == pic_pkg::TRIGGER_PORT) begin
				rdata_q <= trig_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			intr_q    <= 1'b0;
			ack_valid <= 1'b0;
			ack_level <= 3'h0;
		end else if (ce) begin
			intr_q    <= int_ok;
			ack_valid <= ack_go;
			if (ack_go) begin
				ack_level <= p_top[2:0];
			end
		end
	end

	assign bus.io_rdata = rdata_q;
	assign bus.intr     = intr_q;

endmodule

`default_nettype wire

// [logic/pic_host.sv]
// Processor-side controller issuing I/O cycles to the interrupt controller
`timescale 1ns/1ps
`default_nettype none

module pic_host (
	input  wire logic        clock,      // system clock
	input  wire logic        srst,       // synchronous reset
	input  wire logic        ce,         // clock enable
	pic_if.host              bus,        // I/O bus to the device
	input  wire logic [2:0]  reg_addr,   // register index
	input  wire logic [15:0] reg_wdata,  // write data
	input  wire logic        reg_wr,     // write strobe
	input  wire logic        reg_rd,     // read strobe
	output logic      [15:0] reg_rdata,  // read data, next cycle
	output logic             irq         // level interrupt
);

	logic [11:0] addr_q;
	logic [7:0]  wdata_q;
	logic        wr_q, rd_q, rd_wait_q;
	logic [7:0]  result_q;
	logic [1:0]  status_q, mask_q;
	logic        intr_prev_q;
	logic [1:0]  ev_set;
	logic [15:0] rdata_q;

	// ----------------------------------------------------------------
	// I/O cycle generation
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			addr_q  <= 12'h000;
			wdata_q <= 8'h00;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
		end else if (ce) begin
			wr_q <= reg_wr && reg_addr == pic_pkg::HREG_WRITE;
			rd_q <= reg_wr && reg_addr == pic_pkg::HREG_READ;
			if (reg_wr && reg_addr == pic_pkg::HREG_ADDR) begin
				addr_q <= reg_wdata[11:0];
			end
			if (reg_wr && reg_addr == pic_pkg::HREG_WRITE) begin
				wdata_q <= reg_wdata[7:0];
			end
		end
	end

	// Device answers one cycle after the read strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			rd_wait_q <= 1'b0;
			result_q  <= 8'h00;
		end else if (ce) begin
			rd_wait_q <= rd_q;
			if (rd_wait_q) begin
				result_q <= bus.io_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Events, status and mask
	// ----------------------------------------------------------------
	assign ev_set = {bus.intr && !intr_prev_q, rd_wait_q};

	always_ff @(posedge clock) begin
		if (srst) begin
			intr_prev_q <= 1'b0;
			status_q    <= pic_pkg::HSTATUS_RST;
			mask_q      <= pic_pkg::HMASK_RST;
		end else if (ce) begin
			intr_prev_q <= bus.intr;
			// Set wins over write-one-to-clear
			if (reg_wr && reg_addr == pic_pkg::HREG_STATUS) begin
				status_q <= (status_q & ~reg_wdata[1:0]) | ev_set;
			end else begin
				status_q <= status_q | ev_set;
			end
			if (reg_wr && reg_addr == pic_pkg::HREG_MASK) begin
				mask_q <= reg_wdata[1:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_q <= 16'h0000;
		end else if (ce) begin
			rdata_q <= 16'h0000;
			if (reg_rd) begin
				unique case (reg_addr)
					pic_pkg::HREG_ADDR:   rdata_q <= {4'h0, addr_q};
					pic_pkg::HREG_WRITE:  rdata_q <= {8'h00, wdata_q};
					pic_pkg::HREG_RESULT: rdata_q <= {8'h00, result_q};
					pic_pkg::HREG_STATUS: rdata_q <= {13'h0000, bus.intr, status_q};
					pic_pkg::HREG_MASK:   rdata_q <= {14'h0000, mask_q};
					default:              rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	assign reg_rdata    = rdata_q;
	assign irq          = |(status_q & mask_q);
	assign bus.io_addr  = addr_q;
	assign bus.io_wdata = wdata_q;
	assign bus.io_wr    = wr_q;
	assign bus.io_rd    = rd_q;

endmodule

`default_nettype wire

// [verification/pic_bus_checker.sv]
// Concurrent checks on the I/O bus joining host and device ends
`timescale 1ns/1ps
`default_nettype none

module pic_bus_checker (
	input  wire logic        clock,     // system clock
	input  wire logic        srst,      // sync reset, high
	input  wire logic [11:0] io_addr,   // port address
	input  wire logic [7:0]  io_wdata,  // write byte
	input  wire logic        io_wr,     // write strobe
	input  wire logic        io_rd,     // read strobe
	input  wire logic [7:0]  io_rdata,  // read byte
	input  wire logic        intr       // interrupt request
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// Shadow state of the trigger register and poll request
	// ----------------------------------------------------------------
	logic [7:0] trig_q;
	logic       poll_q;
	wire logic  base_wr = io_wr && io_addr == pic_pkg::BASE_PORT;
	wire logic  init_wr = base_wr && io_wdata[4];

	always_ff @(posedge clock) begin
		if (srst)
			trig_q <= 8'h00;
		else if (io_wr && io_addr == pic_pkg::TRIGGER_PORT)
			trig_q <= io_wdata & 8'hf8;
	end

	// Any read of either controller port consumes the poll
	always_ff @(posedge clock) begin
		if (srst || init_wr)
			poll_q <= 1'b0;
		else if (base_wr && io_wdata[4:3] == 2'h1)
			poll_q <= io_wdata[2];
		else if (io_rd && io_addr[11:1] == 11'h010)
			poll_q <= 1'b0;
	end

	sequence trig_rd;
		io_rd && io_addr == pic_pkg::TRIGGER_PORT;
	endsequence
	sequence poll_rd;
		io_rd && poll_q && io_addr == pic_pkg::BASE_PORT;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	rdata_idle_a: assert property (io_rdata != 8'h00 |-> $past(io_rd))
		else $error("read data outside the read answer cycle");
	strobe_excl_a: assert property (!(io_wr && io_rd))
		else $error("write and read strobes together");
	reset_quiet_a: assert property ($past(srst) |-> !intr && io_rdata == 8'h00)
		else $error("outputs not quiet after reset");
	trig_read_a: assert property (trig_rd |=> io_rdata == $past(trig_q))
		else $error("trigger register readback wrong");
	unmapped_zero_a: assert property (io_rd && io_addr != pic_pkg::TRIGGER_PORT
		&& io_addr[11:1] != 11'h010 |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	poll_form_a: assert property (poll_rd |=> io_rdata[6:3] == 4'h0)
		else $error("poll word has stray bits");
	poll_empty_a: assert property (poll_rd ##1 !io_rdata[7] |-> io_rdata == 8'h00)
		else $error("empty poll word not zero");
	init_quiet_a: assert property (init_wr |-> ##2 !intr)
		else $error("interrupt still high after init");
endmodule

`default_nettype wire

// [verification/pic_operation_and_trigger_control_bench.sv]
// Bench driving both ends through the host register port
`timescale 1ns/1ps
`default_nettype none

module pic_operation_and_trigger_control_bench;
	logic        clock;
	logic        srst;
	logic [7:0]  irq_in;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        irq;
	logic [15:0] rd_val;
	logic        auto_end_of_interrupt;
	logic        inta;
	logic        ack_valid;
	logic [2:0]  ack_level;
	int          err_count;
	int          comparisons;

	pic_if pic_if_inst ();

	// Mask register lies outside this block's scope
	pic_device pic_device_inst (.clock(clock), .srst(srst), .ce(1'b1), .bus(pic_if_inst.dev),
		.irq_in(irq_in), .line_mask(8'h00), .auto_end_of_interrupt_mode(auto_end_of_interrupt), .inta(inta),
		.ack_valid(ack_valid), .ack_level(ack_level));
	pic_host pic_host_inst (.clock(clock), .srst(srst), .ce(1'b1), .bus(pic_if_inst.host),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	pic_bus_checker pic_bus_checker_inst (.clock(clock), .srst(srst),
		.io_addr(pic_if_inst.io_addr), .io_wdata(pic_if_inst.io_wdata),
		.io_wr(pic_if_inst.io_wr), .io_rd(pic_if_inst.io_rd),
		.io_rdata(pic_if_inst.io_rdata), .intr(pic_if_inst.intr));

	// ----------------------------------------------------------------
	// Access and comparison tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic io_write(input logic [11:0] port, input logic [7:0] b);
		reg_write(pic_pkg::HREG_ADDR, {4'h0, port});
		reg_write(pic_pkg::HREG_WRITE, {8'h00, b});
	endtask

	task automatic cmd(input logic [7:0] b);
		io_write(pic_pkg::BASE_PORT, b);
	endtask

	// Bounded wait on the read-done flag; a hang ends the run
	task automatic io_expect(input logic [11:0] port, input logic [7:0] exp, input string what);
		logic [15:0] s;
		reg_write(pic_pkg::HREG_STATUS, 16'h0001);
		reg_write(pic_pkg::HREG_ADDR, {4'h0, port});
		reg_write(pic_pkg::HREG_READ, 16'h0000);
		s = 16'h0000;
		for (int i = 0; i < 10 && s[0] !== 1'b1; i++)
			reg_read(pic_pkg::HREG_STATUS, s);
		if (s[0] !== 1'b1) begin
			err_count++;
			give_verdict();
		end
		reg_read(pic_pkg::HREG_RESULT, s);
		check(what, {8'h00, exp}, {8'h00, s[7:0]});
	endtask

	task automatic base(input logic [7:0] exp, input string what);
		io_expect(pic_pkg::BASE_PORT, exp, what);
	endtask

	// Second read lets the live flag catch up with the command
	task automatic live(input logic exp);
		reg_read(pic_pkg::HREG_STATUS, rd_val);
		reg_read(pic_pkg::HREG_STATUS, rd_val);
		check("live intr", {15'h0, exp}, {15'h0, rd_val[pic_pkg::LIVE_INTR]});
	endtask

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] trig_in [3] = '{8'hff, 8'ha8, 8'h07};
		logic [7:0] trig_ex [3] = '{8'hf8, 8'ha8, 8'h00};
		srst        = 1'b1;
		irq_in      = 8'h00;
		auto_end_of_interrupt        = 1'b0;
		inta        = 1'b0;
		reg_addr    = 3'h0;
		reg_wdata   = 16'h0000;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		err_count   = 0;
		comparisons = 0;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		io_expect(pic_pkg::TRIGGER_PORT, 8'h00, "trigger reset");
		for (int i = 0; i < 3; i++) begin
			io_write(pic_pkg::TRIGGER_PORT, trig_in[i]);
			io_expect(pic_pkg::TRIGGER_PORT, trig_ex[i], "trigger");
		end
		io_expect(12'h123, 8'h00, "unmapped port");
		reg_read(3'h7, rd_val);
		check("unmapped index", 16'h0000, rd_val);
		reg_write(pic_pkg::HREG_MASK, 16'h0002);
		irq_in <= 8'h10;
		base(8'h10, "request reg");
		check("irq raised", 16'h0001, {15'h0, irq});
		reg_write(pic_pkg::HREG_STATUS, 16'h0002);
		#1 check("irq cleared", 16'h0000, {15'h0, irq});
		cmd(8'h0c);
		base(8'h84, "poll line 4");
		cmd(8'h0b);
		base(8'h10, "in-service");
		base(8'h10, "in-service again");
		cmd(8'h08);
		base(8'h10, "selection kept");
		cmd(8'h20);
		base(8'h00, "after eoi");
		irq_in <= 8'h70;
		cmd(8'h0c);
		base(8'h85, "poll line 5");
		cmd(8'h65);
		base(8'h00, "after specific eoi");
		cmd(8'h0c);
		base(8'h86, "poll line 6");
		cmd(8'ha0);
		base(8'h00, "after rotate eoi");
		irq_in <= 8'hf4;
		cmd(8'h0c);
		base(8'h87, "rotated poll");
		cmd(8'h67);
		cmd(8'he1);
		irq_in <= 8'hf5;
		cmd(8'h0c);
		base(8'h82, "specific rotate");
		cmd(8'h80);
		cmd(8'h00);
		cmd(8'h0c);
		base(8'h00, "poll blocked by service");
		irq_in <= 8'hfd;
		live(1'b0);
		cmd(8'h68);
		live(1'b1);
		cmd(8'h48);
		live(1'b1);
		cmd(8'h28);
		live(1'b0);
		cmd(8'h10);
		base(8'h00, "after init");
		// Auto end of interrupt: acknowledge leaves no in-service bit
		auto_end_of_interrupt   <= 1'b1;
		irq_in <= 8'hff;
		repeat (2) @(posedge clock);
		inta <= 1'b1;
		@(posedge clock);
		inta <= 1'b0;
		#1 check("ack valid and level", 16'h0009, {12'h000, ack_valid, ack_level});
		base(8'h00, "request after ack");
		cmd(8'h0b);
		base(8'h00, "auto eoi in-service");
		give_verdict();
	end
endmodule

`default_nettype wire
